// ==== verilog/clk_ctrl_map.svh ====
`ifndef CLK_CTRL_MAP_SVH
`define CLK_CTRL_MAP_SVH
// ----------------------------------------
// Source select codes
// ----------------------------------------
`define CODE_EXT 4'h0
`define CODE_RSVD 4'h1
`define CODE_CALRC 4'h2
`define CODE_RC128 4'h3
`define CODE_LF_LO 4'h4
`define CODE_LF_HI 4'h5
`define CODE_LP_LO 4'h8
// ----------------------------------------
// Shipped fuse image, zero is programmed
// ----------------------------------------
`define CODE_RST 4'h2
`define STF_RST 2'h2
`define DIV8_RST 1'b0
`define FUSE_PROG 1'b0
// ----------------------------------------
// Time-out and start-up counts
// ----------------------------------------
`define STF_NONE 2'h0
`define STF_SHORT 2'h1
`define WDT_OSC_KHZ 128
`define TOUT_SHORT_US 4000
`define TOUT_LONG_US 65000
`define TOUT_W 14
`define SU_W 16
`define SU_EXT 16'h0006
`define SU_RC 16'h0006
`define SU_258 16'h0102
`define SU_1K 16'h0400
`define SU_16K 16'h4000
`define SU_32K 16'h8000
`define DIV8_LAST 3'h7
`endif

// ==== verilog/clk_ctrl_pkg.sv ====
package clk_ctrl_pkg;
    typedef enum logic [2:0] {
        SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN,
        SLP_PWR_SAVE, SLP_STANDBY, SLP_EXT_STANDBY
    } sleep_mode_e;
    typedef enum logic [2:0] {
        SRC_LP_XTAL, SRC_LF_XTAL, SRC_RC128, SRC_CALRC,
        SRC_EXT, SRC_RSVD
    } clk_src_e;
    typedef enum logic [2:0] {
        ST_LOAD, ST_TOUT, ST_START, ST_RUN, ST_SLEEP, ST_WAKE,
        ST_FAULT
    } seq_state_e;
endpackage : clk_ctrl_pkg

// ==== verilog/edge_if.sv ====
`timescale 1ns/10ps
interface edge_if;
    logic level;
    logic rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface : edge_if

// ==== verilog/edge_sync.sv ====
`timescale 1ns/10ps
module edge_sync (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    edge_if.src edge_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_s;
    sync_s state_reg;
    sync_s state_next;
    always_comb begin
        state_next = state_reg;
        state_next.meta = pin_i;
        state_next.sync = state_reg.meta;
        state_next.last = state_reg.sync;
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign edge_o.level = state_reg.sync;
    assign edge_o.rise = state_reg.sync & ~state_reg.last;
endmodule : edge_sync

// ==== verilog/sys_prescaler.sv ====
`timescale 1ns/10ps
`include "clk_ctrl_map.svh"
module sys_prescaler (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic div8_fuse_i,
    edge_if.dst osc_i,
    output logic tick_o
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } presc_s;
    presc_s state_reg;
    presc_s state_next;
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run_i) begin
            state_next.cnt = 3'h0;
        end else if (osc_i.rise) begin
            if (div8_fuse_i == `FUSE_PROG) begin
                if (state_reg.cnt == `DIV8_LAST) begin
                    state_next.cnt = 3'h0;
                    state_next.tick = 1'b1;
                end else begin
                    state_next.cnt = state_reg.cnt + 3'h1;
                end
            end else begin
                state_next.tick = 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign tick_o = state_reg.tick;
endmodule : sys_prescaler

// ==== verilog/clock_select_startup.sv ====
`timescale 1ns/10ps
`include "clk_ctrl_map.svh"
module clock_select_startup #(
    parameter int TOUT_LONG_CYC =
        `TOUT_LONG_US * `WDT_OSC_KHZ / 1000
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic other_reset_n_i,
    input wire logic [3:0] clock_source_select_fuses_i,
    input wire logic [1:0] startup_time_fuses_i,
    input wire logic divide_by_eight_fuse_i,
    input wire logic osc_clk_i,
    input wire logic wdt_osc_i,
    input wire logic tosc_i,
    input wire logic level_irq_i,
    input clk_ctrl_pkg::sleep_mode_e sleep_mode_i,
    input wire logic wake_i,
    output logic internal_reset_n_o,
    output logic cpu_clk_en_o,
    output logic io_clk_en_o,
    output logic flash_clk_en_o,
    output logic adc_clk_en_o,
    output logic async_timer_clock_en_o,
    output logic twi_addr_en_o,
    output logic osc_enable_o,
    output logic level_irq_o,
    output logic fuse_fault_o,
    output clk_ctrl_pkg::clk_src_e source_o
);
    import clk_ctrl_pkg::*;

    localparam int TOUT_SHORT_CYC =
        `TOUT_SHORT_US * `WDT_OSC_KHZ / 1000;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] fuse_meta;
        logic [6:0] fuse_sync;
        logic rsrc_meta;
        logic rsrc_sync;
        logic irq_meta;
        logic irq_sync;
        logic [3:0] code;
        logic [1:0] stf;
        logic div8;
        clk_src_e src;
        seq_state_e state;
        logic [`TOUT_W-1:0] tout_cnt;
        logic [`SU_W-1:0] su_cnt;
        logic run;
        logic int_rst_n;
        logic cpu_en;
        logic io_en;
        logic flash_en;
        logic adc_en;
        logic asy_en;
        logic twi_en;
        logic osc_en;
        logic irq;
        logic fault;
    } top_s;

    localparam top_s TOP_RST = '{
        fuse_meta: 7'h00,
        fuse_sync: 7'h00,
        rsrc_meta: 1'b0,
        rsrc_sync: 1'b0,
        irq_meta: 1'b0,
        irq_sync: 1'b0,
        code: `CODE_RST,
        stf: `STF_RST,
        div8: `DIV8_RST,
        src: SRC_CALRC,
        state: ST_LOAD,
        tout_cnt: '0,
        su_cnt: '0,
        run: 1'b0,
        int_rst_n: 1'b0,
        cpu_en: 1'b0,
        io_en: 1'b0,
        flash_en: 1'b0,
        adc_en: 1'b0,
        asy_en: 1'b0,
        twi_en: 1'b0,
        osc_en: 1'b1,
        irq: 1'b0,
        fault: 1'b0
    };

    logic [1:0] rst_pipe_reg;
    logic rst_n;
    logic sys_tick;
    top_s state_reg;
    top_s state_next;

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    function automatic clk_src_e decode_src(input logic [3:0] code);
        clk_src_e res;
        res = SRC_RSVD;
        if (code >= `CODE_LP_LO) begin
            res = SRC_LP_XTAL;
        end else if (code == `CODE_LF_LO || code == `CODE_LF_HI) begin
            res = SRC_LF_XTAL;
        end else if (code == `CODE_RC128) begin
            res = SRC_RC128;
        end else if (code == `CODE_CALRC) begin
            res = SRC_CALRC;
        end else if (code == `CODE_EXT) begin
            res = SRC_EXT;
        end else begin
            res = SRC_RSVD;
        end
        return res;
    endfunction : decode_src

    function automatic logic [`SU_W-1:0] startup_count(
        input clk_src_e src,
        input logic sel0,
        input logic [1:0] stf
    );
        logic [`SU_W-1:0] res;
        res = `SU_EXT;
        case (src)
            SRC_LP_XTAL: begin
                case ({sel0, stf})
                    3'h0, 3'h1: res = `SU_258;
                    3'h2, 3'h3, 3'h4: res = `SU_1K;
                    default: res = `SU_16K;
                endcase
            end
            SRC_LF_XTAL: res = `SU_32K;
            SRC_RC128, SRC_CALRC: res = `SU_RC;
            default: res = `SU_EXT;
        endcase
        return res;
    endfunction : startup_count

    function automatic logic [`TOUT_W-1:0] timeout_count(
        input logic [1:0] stf
    );
        logic [`TOUT_W-1:0] res;
        res = '0;
        case (stf)
            `STF_NONE: res = '0;
            `STF_SHORT: res = `TOUT_W'(TOUT_SHORT_CYC);
            default: res = `TOUT_W'(TOUT_LONG_CYC);
        endcase
        return res;
    endfunction : timeout_count

    function automatic logic io_awake(input sleep_mode_e mode);
        return (mode == SLP_ACTIVE) || (mode == SLP_IDLE);
    endfunction : io_awake

    function automatic logic adc_awake(input sleep_mode_e mode);
        return io_awake(mode) || (mode == SLP_ADC_NR);
    endfunction : adc_awake

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // ----------------------------------------
    // Pin edges and prescaler
    // ----------------------------------------
    edge_if osc_e ();
    edge_if wdt_e ();
    edge_if tosc_e ();

    edge_sync u_osc_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pin_i(osc_clk_i),
        .edge_o(osc_e)
    );

    edge_sync u_wdt_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pin_i(wdt_osc_i),
        .edge_o(wdt_e)
    );

    edge_sync u_tosc_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pin_i(tosc_i),
        .edge_o(tosc_e)
    );

    sys_prescaler u_presc (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .run_i(state_reg.run),
        .div8_fuse_i(state_reg.div8),
        .osc_i(osc_e),
        .tick_o(sys_tick)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.fuse_meta = {clock_source_select_fuses_i,
                                startup_time_fuses_i,
                                divide_by_eight_fuse_i};
        state_next.fuse_sync = state_reg.fuse_meta;
        state_next.rsrc_meta = other_reset_n_i;
        state_next.rsrc_sync = state_reg.rsrc_meta;
        state_next.irq_meta = level_irq_i;
        state_next.irq_sync = state_reg.irq_meta;
        state_next.cpu_en = 1'b0;
        state_next.io_en = 1'b0;
        state_next.flash_en = 1'b0;
        state_next.adc_en = 1'b0;
        state_next.irq = 1'b0;
        state_next.asy_en = tosc_e.rise;
        state_next.twi_en = 1'b1;
        if (!state_reg.rsrc_sync && state_reg.state != ST_LOAD) begin
            state_next.state = ST_LOAD;
            state_next.int_rst_n = 1'b0;
            state_next.run = 1'b0;
            state_next.osc_en = 1'b1;
            state_next.fault = 1'b0;
        end else begin
            case (state_reg.state)
                ST_LOAD: begin
                    state_next.int_rst_n = 1'b0;
                    state_next.run = 1'b0;
                    state_next.osc_en = 1'b1;
                    state_next.fault = 1'b0;
                    if (state_reg.rsrc_sync) begin
                        state_next.code = state_reg.fuse_sync[6:3];
                        state_next.stf = state_reg.fuse_sync[2:1];
                        state_next.div8 = state_reg.fuse_sync[0];
                        state_next.src =
                            decode_src(state_reg.fuse_sync[6:3]);
                        state_next.tout_cnt =
                            timeout_count(state_reg.fuse_sync[2:1]);
                        state_next.su_cnt = startup_count(
                            decode_src(state_reg.fuse_sync[6:3]),
                            state_reg.fuse_sync[3],
                            state_reg.fuse_sync[2:1]);
                        if (decode_src(state_reg.fuse_sync[6:3])
                            == SRC_RSVD) begin
                            state_next.state = ST_FAULT;
                        end else begin
                            state_next.state = ST_TOUT;
                        end
                    end
                end
                ST_TOUT: begin
                    if (state_reg.tout_cnt == '0) begin
                        state_next.state = ST_START;
                    end else if (wdt_e.rise) begin
                        state_next.tout_cnt =
                            state_reg.tout_cnt - `TOUT_W'(1);
                    end
                end
                ST_START: begin
                    if (osc_e.rise) begin
                        if (state_reg.su_cnt <= `SU_W'(1)) begin
                            state_next.state = ST_RUN;
                            state_next.int_rst_n = 1'b1;
                            state_next.run = 1'b1;
                        end else begin
                            state_next.su_cnt =
                                state_reg.su_cnt - `SU_W'(1);
                        end
                    end
                end
                ST_RUN: begin
                    state_next.cpu_en = sys_tick &&
                        sleep_mode_i == SLP_ACTIVE;
                    state_next.flash_en = sys_tick &&
                        sleep_mode_i == SLP_ACTIVE;
                    state_next.io_en = sys_tick &&
                        io_awake(sleep_mode_i);
                    state_next.adc_en = sys_tick &&
                        adc_awake(sleep_mode_i);
                    if (sleep_mode_i == SLP_PWR_DOWN ||
                        sleep_mode_i == SLP_PWR_SAVE) begin
                        state_next.state = ST_SLEEP;
                        state_next.osc_en = 1'b0;
                        state_next.run = 1'b0;
                    end
                end
                ST_SLEEP: begin
                    if (wake_i) begin
                        state_next.state = ST_WAKE;
                        state_next.osc_en = 1'b1;
                        state_next.su_cnt = startup_count(
                            state_reg.src, state_reg.code[0],
                            state_reg.stf);
                    end
                end
                ST_WAKE: begin
                    if (osc_e.rise) begin
                        if (state_reg.su_cnt <= `SU_W'(1)) begin
                            state_next.state = ST_RUN;
                            state_next.run = 1'b1;
                            state_next.irq = state_reg.irq_sync;
                        end else begin
                            state_next.su_cnt =
                                state_reg.su_cnt - `SU_W'(1);
                        end
                    end
                end
                ST_FAULT: begin
                    state_next.int_rst_n = 1'b0;
                    state_next.fault = 1'b1;
                    state_next.run = 1'b0;
                end
                default: begin
                    state_next.state = ST_LOAD;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= TOP_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign internal_reset_n_o = state_reg.int_rst_n;
    assign cpu_clk_en_o = state_reg.cpu_en;
    assign io_clk_en_o = state_reg.io_en;
    assign flash_clk_en_o = state_reg.flash_en;
    assign adc_clk_en_o = state_reg.adc_en;
    assign async_timer_clock_en_o = state_reg.asy_en;
    assign twi_addr_en_o = state_reg.twi_en;
    assign osc_enable_o = state_reg.osc_en;
    assign level_irq_o = state_reg.irq;
    assign fuse_fault_o = state_reg.fault;
    assign source_o = state_reg.src;
endmodule : clock_select_startup

// ==== sim/clock_select_startup_sva.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Clock control checker
// ----------------------------------------
module clock_select_startup_chk
    import clk_ctrl_pkg::*;
#(
    parameter int TOUT_LONG_CYC = 8320
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input clk_ctrl_pkg::sleep_mode_e sleep_mode_i,
    input wire logic internal_reset_n_o,
    input wire logic cpu_clk_en_o,
    input wire logic io_clk_en_o,
    input wire logic flash_clk_en_o,
    input wire logic adc_clk_en_o,
    input wire logic async_timer_clock_en_o,
    input wire logic twi_addr_en_o,
    input wire logic osc_enable_o,
    input wire logic level_irq_o,
    input wire logic fuse_fault_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    a_flash_with_cpu: assert property (
        flash_clk_en_o == cpu_clk_en_o)
        else $error("flash enable differs from core enable");
    a_core_active_only: assert property (
        cpu_clk_en_o |-> sleep_mode_i == SLP_ACTIVE
            || $past(sleep_mode_i) == SLP_ACTIVE)
        else $error("core enable outside active mode");
    a_io_mode_gate: assert property (
        io_clk_en_o |-> sleep_mode_i inside {SLP_ACTIVE, SLP_IDLE}
            || $past(sleep_mode_i) inside {SLP_ACTIVE, SLP_IDLE})
        else $error("io enable in wrong mode");
    a_adc_mode_gate: assert property (
        adc_clk_en_o |->
            sleep_mode_i inside {SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR}
            || $past(sleep_mode_i) inside {SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR})
        else $error("converter enable in wrong mode");
    a_common_rate: assert property (
        cpu_clk_en_o |-> io_clk_en_o && adc_clk_en_o)
        else $error("domain enables not aligned");
    a_reset_no_clk: assert property (
        !internal_reset_n_o |-> !cpu_clk_en_o && !io_clk_en_o
            && !adc_clk_en_o)
        else $error("domain enable while internal reset held");
    a_fault_holds: assert property (
        fuse_fault_o |-> !internal_reset_n_o)
        else $error("reset released on reserved code");
    a_irq_pulse: assert property (
        level_irq_o |-> osc_enable_o ##1 !level_irq_o)
        else $error("wake interrupt not a single pulse");
    a_sleep_stop: assert property (
        $fell(osc_enable_o) |->
            $past(sleep_mode_i) inside {SLP_PWR_DOWN, SLP_PWR_SAVE})
        else $error("oscillator stopped outside deep sleep");
    a_twi_stays: assert property (
        twi_addr_en_o |=> twi_addr_en_o)
        else $error("address recognition dropped");
    a_timer_pulse: assert property (
        async_timer_clock_en_o |=> !async_timer_clock_en_o)
        else $error("timer enable longer than one cycle");
endmodule : clock_select_startup_chk

bind clock_select_startup clock_select_startup_chk #(
    .TOUT_LONG_CYC(TOUT_LONG_CYC)
) u_clock_select_startup_chk (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sleep_mode_i(sleep_mode_i),
    .internal_reset_n_o(internal_reset_n_o),
    .cpu_clk_en_o(cpu_clk_en_o),
    .io_clk_en_o(io_clk_en_o),
    .flash_clk_en_o(flash_clk_en_o),
    .adc_clk_en_o(adc_clk_en_o),
    .async_timer_clock_en_o(async_timer_clock_en_o),
    .twi_addr_en_o(twi_addr_en_o),
    .osc_enable_o(osc_enable_o),
    .level_irq_o(level_irq_o),
    .fuse_fault_o(fuse_fault_o)
);

// ==== sim/osc_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// External oscillators
// ----------------------------------------
module osc_model (
    input wire logic osc_enable_i,
    output logic osc_clk_o,
    output logic wdt_osc_o,
    output logic tosc_o
);
    // Main oscillator stands still while disabled
    always begin
        if (osc_enable_i === 1'b1) begin
            #20 osc_clk_o = (osc_clk_o !== 1'b1);
        end else begin
            osc_clk_o = 1'b0;
            @(posedge osc_enable_i);
        end
    end
    // Watchdog oscillator, main period, shifted
    initial begin
        wdt_osc_o = 1'b0;
        #10;
        forever #20 wdt_osc_o = ~wdt_osc_o;
    end
    // Timer crystal runs through sleep
    initial begin
        tosc_o = 1'b0;
        forever #25 tosc_o = ~tosc_o;
    end
endmodule : osc_model

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`include "clk_ctrl_map.svh"
module testbench;
    import clk_ctrl_pkg::*;
    localparam int TLONG = 20;
    typedef struct {int n; clk_src_e src;} note_s;
    logic clock_i = 1'b0;
    logic arst_n_i, other_reset_n_i, divide_by_eight_fuse_i;
    logic level_irq_i, wake_i, osc_clk_i, wdt_osc_i, tosc_i;
    logic [3:0] clock_source_select_fuses_i;
    logic [1:0] startup_time_fuses_i;
    sleep_mode_e sleep_mode_i;
    logic internal_reset_n_o, cpu_clk_en_o, io_clk_en_o, flash_clk_en_o;
    logic adc_clk_en_o, async_timer_clock_en_o, twi_addr_en_o;
    logic osc_enable_o, level_irq_o, fuse_fault_o, rst_prev, lvl, hold;
    logic [3:0] code;
    clk_src_e source_o;
    int err_count = 0;
    int checks_done = 0;
    int osc_cnt, cpu_cnt, io_cnt, adc_cnt, irq_seen, i, asy_cnt;
    int seed = 32'h705b;
    note_s notes[$];
    note_s nt;
    sleep_mode_e modes[5] = '{SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR,
        SLP_STANDBY, SLP_EXT_STANDBY};

    always #2.5 clock_i = ~clock_i;

    clock_select_startup #(.TOUT_LONG_CYC(TLONG)) u_clock_select_startup (
        .clock_i(clock_i), .arst_n_i(arst_n_i),
        .other_reset_n_i(other_reset_n_i),
        .clock_source_select_fuses_i(clock_source_select_fuses_i),
        .startup_time_fuses_i(startup_time_fuses_i),
        .divide_by_eight_fuse_i(divide_by_eight_fuse_i),
        .osc_clk_i(osc_clk_i), .wdt_osc_i(wdt_osc_i), .tosc_i(tosc_i),
        .level_irq_i(level_irq_i), .sleep_mode_i(sleep_mode_i),
        .wake_i(wake_i), .internal_reset_n_o(internal_reset_n_o),
        .cpu_clk_en_o(cpu_clk_en_o), .io_clk_en_o(io_clk_en_o),
        .flash_clk_en_o(flash_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
        .async_timer_clock_en_o(async_timer_clock_en_o),
        .twi_addr_en_o(twi_addr_en_o), .osc_enable_o(osc_enable_o),
        .level_irq_o(level_irq_o), .fuse_fault_o(fuse_fault_o),
        .source_o(source_o));

    osc_model u_osc_model (.osc_enable_i(osc_enable_o),
        .osc_clk_o(osc_clk_i), .wdt_osc_o(wdt_osc_i), .tosc_o(tosc_i));

    // ----------------------------------------
    // Compare and verdict
    // ----------------------------------------
    task automatic chk_val(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_rng(input string what, input int lo, input int hi,
            input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
                hi, got);
        end
    endtask : chk_rng

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge osc_clk_i) osc_cnt++;

    always @(posedge clock_i) begin
        if (cpu_clk_en_o === 1'b1) cpu_cnt++;
        if (io_clk_en_o === 1'b1) io_cnt++;
        if (adc_clk_en_o === 1'b1) adc_cnt++;
        if (level_irq_o === 1'b1) irq_seen++;
        if (async_timer_clock_en_o === 1'b1) asy_cnt++;
        if ((internal_reset_n_o === 1'b1 && rst_prev === 1'b0)
                || level_irq_o === 1'b1) begin
            if (notes.size() == 0) begin
                chk_val("unexpected release", 0, 1);
            end else begin
                nt = notes.pop_front();
                chk_rng("osc cycles", nt.n - 1, nt.n + 2, osc_cnt);
                chk_val("source", nt.src, source_o);
            end
        end
        rst_prev <= internal_reset_n_o;
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic run_case(input logic [3:0] cd, input logic [1:0] stf,
            input int n, input clk_src_e src, input logic flt);
        int k;
        @(negedge clock_i);
        other_reset_n_i = 1'b0;
        clock_source_select_fuses_i = cd;
        startup_time_fuses_i = stf;
        repeat (6) @(negedge clock_i);
        other_reset_n_i = 1'b1;
        osc_cnt = 0;
        if (n > 0) begin
            notes.push_back('{n, src});
            k = 0;
            while (internal_reset_n_o !== 1'b1 && k < n * 12 + 100) begin
                @(negedge clock_i);
                k++;
            end
            chk_val("release", 1, internal_reset_n_o);
        end else begin
            repeat (30) @(negedge clock_i);
            chk_val("source", src, source_o);
            chk_val("fault", flt, fuse_fault_o);
            chk_val("held", 0, internal_reset_n_o);
        end
    endtask : run_case

    task automatic rate_check(input sleep_mode_e md, input int r,
            input int ec, input int ei, input int ea);
        @(negedge clock_i);
        sleep_mode_i = md;
        repeat (4) @(negedge clock_i);
        cpu_cnt = 0;
        io_cnt = 0;
        adc_cnt = 0;
        repeat (r * 8) @(negedge clock_i);
        chk_rng("core ticks", ec - (ec > 0), ec + (ec > 0), cpu_cnt);
        chk_rng("io ticks", ei - (ei > 0), ei + (ei > 0), io_cnt);
        chk_rng("adc ticks", ea - (ea > 0), ea + (ea > 0), adc_cnt);
    endtask : rate_check

    initial begin
        arst_n_i = 1'b0;
        other_reset_n_i = 1'b0;
        clock_source_select_fuses_i = `CODE_RST;
        startup_time_fuses_i = `STF_RST;
        divide_by_eight_fuse_i = `DIV8_RST;
        level_irq_i = 1'b0;
        wake_i = 1'b0;
        sleep_mode_i = SLP_ACTIVE;
        repeat (3) @(negedge clock_i);
        chk_val("reset held", 0, internal_reset_n_o);
        chk_val("reset source", SRC_CALRC, source_o);
        chk_val("reset osc", 1, osc_enable_o);
        chk_val("reset fault", 0, fuse_fault_o);
        repeat (2) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        run_case(`CODE_RST, `STF_RST, TLONG + 6, SRC_CALRC, 0);
        rate_check(SLP_ACTIVE, 80, 10, 10, 10);
        divide_by_eight_fuse_i = 1'b1;
        run_case(4'h0, 2'h0, 6, SRC_EXT, 0);
        run_case(4'h3, 2'h1, 512 + 6, SRC_RC128, 0);
        run_case(4'h8, 2'h2, TLONG + 1024, SRC_LP_XTAL, 0);
        code = 4'h8 | 4'($random(seed) & 7);
        run_case(code, 2'h0, code[0] ? 1024 : 258, SRC_LP_XTAL, 0);
        run_case(4'h4, 2'h0, 0, SRC_LF_XTAL, 0);
        run_case(4'h5, 2'h3, 0, SRC_LF_XTAL, 0);
        run_case(4'h1, 2'h0, 0, SRC_RSVD, 1);
        run_case(4'h6, 2'h0, 0, SRC_RSVD, 1);
        run_case(4'h2, 2'h0, 6, SRC_CALRC, 0);
        for (i = 0; i < 5; i++) begin
            rate_check(modes[i], 40, i < 1 ? 40 : 0, i < 2 ? 40 : 0,
                i < 3 ? 40 : 0);
        end
        for (i = 0; i < 4; i++) begin
            lvl = (i == 3) ? 1'b1 : (i < 2 ? i[0] : 1'($random(seed)));
            hold = (i != 3);
            @(negedge clock_i);
            sleep_mode_i = i[0] ? SLP_PWR_SAVE : SLP_PWR_DOWN;
            asy_cnt = 0;
            repeat (6) @(negedge clock_i);
            chk_val("osc stopped", 0, osc_enable_o);
            level_irq_i = lvl;
            repeat (6) @(negedge clock_i);
            chk_rng("timer ticks", 1, 2, asy_cnt);
            chk_val("twi enable", 1, twi_addr_en_o);
            irq_seen = 0;
            if (lvl && hold) notes.push_back('{6, SRC_CALRC});
            wake_i = 1'b1;
            sleep_mode_i = SLP_ACTIVE;
            osc_cnt = 0;
            @(negedge clock_i);
            wake_i = 1'b0;
            if (!hold) level_irq_i = 1'b0;
            repeat (150) @(negedge clock_i);
            chk_val("wake irq", lvl & hold, irq_seen);
            chk_val("awake osc", 1, osc_enable_o);
            level_irq_i = 1'b0;
        end
        give_verdict();
    end

    initial begin
        #300000;
        err_count++;
        give_verdict();
    end
endmodule : testbench
